/* logic/wsc_sequencer.sv */
// sequence table walker with trigger, arm and advancement control
`timescale 1ns/100ps
`include "wsc_defs.svh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module wsc_sequencer #(
    parameter int ENTRIES = 256,
    parameter int GRAN = `WSC_GRAN,
    parameter int SW = `WSC_SAMPLE_W,
    parameter int DEPTH = `WSC_FIFO_DEPTH,
    parameter logic [`WSC_LOOP_W-1:0] PLAY_COUNT = 32'h0000_0001
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sequencing_option,
    input wire logic run,
    input wire logic [1:0] trig_mode,
    input wire logic armed_mode,
    input wire logic infinite_play,
    input wire logic [`WSC_ENTRY_W-1:0] start_ptr,
    input wire logic trigger_pin,
    input wire logic event_pin,
    input wire logic enable_pin,
    input wire logic tbl_we,
    input wire logic [`WSC_ENTRY_W-1:0] tbl_waddr,
    input wire logic [`WSC_ADDR_W-1:0] tbl_base,
    input wire logic [`WSC_LEN_W-1:0] tbl_len,
    input wire logic [`WSC_LOOP_W-1:0] tbl_loops,
    input wire logic [`WSC_ENTRY_W+3:0] tbl_ctrl,
    output logic [`WSC_ADDR_W-1:0] mem_addr,
    output logic mem_req,
    input wire logic [GRAN*SW-1:0] mem_data,
    output logic [GRAN*SW-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic running,
    output logic holding,
    output logic [`WSC_ENTRY_W-1:0] cur_entry
);
    localparam int EW = `WSC_ENTRY_W;
    localparam int CW = EW + 4;
    // table: one sequence vector per entry
    // vector storage
    logic [`WSC_ADDR_W-1:0] base_q [ENTRIES];
    logic [`WSC_LEN_W-1:0] len_q [ENTRIES];
    logic [`WSC_LOOP_W-1:0] loops_q [ENTRIES];
    logic [CW-1:0] ctrl_q [ENTRIES];
    always_ff @(posedge clk) begin
        if (tbl_we) begin
            base_q[tbl_waddr] <= tbl_base;
            len_q[tbl_waddr] <= tbl_len;
            loops_q[tbl_waddr] <= tbl_loops;
            ctrl_q[tbl_waddr] <= tbl_ctrl;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage read only by second
    logic [2:0] s1_q, s2_q, s3_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
        end else begin
            s1_q <= {enable_pin, event_pin, trigger_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    logic trig_lvl, trig_rise, trig_fall, ev_rise, en_rise, en_lvl;
    assign trig_lvl = s2_q[0];
    assign trig_rise = s2_q[0] && !s3_q[0];
    assign trig_fall = !s2_q[0] && s3_q[0];
    assign ev_rise = s2_q[1] && !s3_q[1];
    assign en_rise = s2_q[2] && !s3_q[2];
    assign en_lvl = s2_q[2];

    //////////////////////////////////////////////////////////////////////////
    wsc_pkg::wsc_state_t st_q, st_d;
    logic [EW-1:0] ent_q, ent_d;
    logic [`WSC_LEN_W-1:0] pos_q, pos_d;
    logic [`WSC_LOOP_W-1:0] iter_q, iter_d;
    logic [`WSC_LOOP_W-1:0] back_q [ENTRIES];
    logic [`WSC_LOOP_W-1:0] plays_q, plays_d;
    logic ev_q, ev_d, enflag_q, enflag_d;
    logic armhold_q, armhold_d, bk_we;
    logic [`WSC_LOOP_W-1:0] bk_val;
    logic [EW-1:0] bk_idx;

    wsc_pkg::wsc_trig_t tm;
    wsc_pkg::wsc_adv_t adv;
    logic seg_end, iter_last, last_ent, loop_end, adv_go, started, push;
    logic fifo_ready, ev_use, eff_seq, eff_armed, gv_q;
    logic [EW-1:0] lb_ent;

    always_comb begin
        // no sequencing option forces plain self armed
        eff_seq = sequencing_option;
        eff_armed = armed_mode && sequencing_option;
        tm = wsc_pkg::wsc_trig_t'(trig_mode);
        adv = wsc_pkg::wsc_adv_t'(ctrl_q[ent_q][`WSC_ADV_LSB +: 2]);
        last_ent = ctrl_q[ent_q][`WSC_LAST_F] || !eff_seq;
        loop_end = ctrl_q[ent_q][`WSC_LOOP_END_F] && eff_seq;
        lb_ent = ctrl_q[ent_q][`WSC_LOOPBACK_LSB +: EW];
        // one granule per sync cycle when fifo accepts
        // granule register acts as a skid stage, so a full fifo loses none
        push = (st_q == wsc_pkg::WSC_ST_PLAY) && (fifo_ready || !gv_q);
        seg_end = push && (pos_q + `WSC_LEN_W'(GRAN) >= len_q[ent_q]);
        // 32 bit loop count compared as unsigned
        iter_last = (iter_q + 32'h0000_0001 >= loops_q[ent_q]);
        st_d = st_q;
        ent_d = ent_q;
        pos_d = push ? pos_q + `WSC_LEN_W'(GRAN) : pos_q;
        iter_d = iter_q;
        plays_d = plays_q;
        armhold_d = armhold_q;
        bk_we = 1'b0;
        bk_idx = ent_q;
        bk_val = 32'h0000_0000;
        ev_use = 1'b0;
        adv_go = 1'b0;
        // enable flag remembered as start condition
        enflag_d = enflag_q || en_lvl;
        started = 1'b0;
        unique case (st_q)
            wsc_pkg::WSC_ST_IDLE: begin
                if (run) begin
                    unique case (tm)
                        wsc_pkg::WSC_TRIG_CONT: started = 1'b1;
                        wsc_pkg::WSC_TRIG_TRIG: started = trig_rise;
                        default: started = trig_rise;
                    endcase
                    // self armed: trigger mode alone decides
                    if (eff_armed && !(tm == wsc_pkg::WSC_TRIG_CONT)) begin
                        started = started && enflag_q;
                    end
                end
                if (started) begin
                    st_d = wsc_pkg::WSC_ST_PLAY;
                    ent_d = start_ptr;
                    pos_d = '0;
                    iter_d = '0;
                    plays_d = '0;
                    armhold_d = eff_armed && (tm == wsc_pkg::WSC_TRIG_CONT);
                    enflag_d = 1'b0;
                end
            end
            wsc_pkg::WSC_ST_PLAY: begin
                if (seg_end) begin
                    pos_d = '0;
                    if (armhold_q) begin
                        adv_go = en_rise;
                        armhold_d = !en_rise;
                    end else begin
                        unique case (adv)
                            wsc_pkg::WSC_ADV_AUTO: adv_go = iter_last;
                            wsc_pkg::WSC_ADV_COND: adv_go = ev_q;
                            wsc_pkg::WSC_ADV_REPEAT: begin
                                if (iter_last) begin
                                    st_d = wsc_pkg::WSC_ST_HOLD;
                                end
                            end
                            default: st_d = wsc_pkg::WSC_ST_HOLD;
                        endcase
                        ev_use = (adv == wsc_pkg::WSC_ADV_COND) && ev_q;
                    end
                    if (!adv_go && st_d == wsc_pkg::WSC_ST_PLAY) begin
                        iter_d = iter_last ? '0 : iter_q + 32'h0000_0001;
                    end
                end
            end
            wsc_pkg::WSC_ST_HOLD: begin
                if (ev_q) begin
                    ev_use = 1'b1;
                    if (adv == wsc_pkg::WSC_ADV_SINGLE && !iter_last) begin
                        st_d = wsc_pkg::WSC_ST_PLAY;
                        iter_d = iter_q + 32'h0000_0001;
                    end else begin
                        st_d = wsc_pkg::WSC_ST_PLAY;
                        adv_go = 1'b1;
                    end
                end
            end
            default: begin
                if (trig_rise) begin
                    st_d = wsc_pkg::WSC_ST_PLAY;
                end
            end
        endcase
        if (adv_go) begin
            iter_d = '0;
            if (loop_end && back_q[ent_q] + 32'h0000_0001 < loops_q[lb_ent]
                && loops_q[lb_ent] != 32'h0000_0000) begin
                // jump back while loop count remains
                bk_we = 1'b1;
                bk_val = back_q[ent_q] + 32'h0000_0001;
                ent_d = lb_ent;
            end else if (!last_ent) begin
                if (loop_end) begin
                    bk_we = 1'b1;
                end
                ent_d = ent_q + 1'b1;
            end else begin
                if (loop_end) begin
                    bk_we = 1'b1;
                end
                plays_d = plays_q + 32'h0000_0001;
                ent_d = start_ptr;
                if (tm == wsc_pkg::WSC_TRIG_TRIG && !infinite_play
                    && plays_q + 32'h0000_0001 >= PLAY_COUNT) begin
                    st_d = wsc_pkg::WSC_ST_IDLE;
                end
            end
        end
        if (tm == wsc_pkg::WSC_TRIG_GATE && trig_fall
            && st_q != wsc_pkg::WSC_ST_IDLE) begin
            st_d = wsc_pkg::WSC_ST_PAUSE;
        end
        if (!run) begin
            st_d = wsc_pkg::WSC_ST_IDLE;
        end
        ev_d = (ev_q && !ev_use) || ev_rise;
    end

    always_ff @(posedge clk) begin
        // synchronous reset to idle, events dropped
        if (reset) begin
            st_q <= wsc_pkg::WSC_ST_IDLE;
            ent_q <= '0;
            pos_q <= '0;
            iter_q <= '0;
            plays_q <= '0;
            ev_q <= 1'b0;
            enflag_q <= 1'b0;
            armhold_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ent_q <= ent_d;
            pos_q <= pos_d;
            iter_q <= iter_d;
            plays_q <= plays_d;
            ev_q <= ev_d;
            enflag_q <= enflag_d;
            armhold_q <= armhold_d;
        end
        if (bk_we) begin
            back_q[bk_idx] <= bk_val;
        end
        // a freshly written entry starts with no loop passes counted
        if (tbl_we) begin
            back_q[tbl_waddr] <= '0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // fetch address from entry base; entries may share a base
    assign mem_addr = base_q[ent_q] + `WSC_ADDR_W'(pos_q);
    assign mem_req = push;
    // a gate pause reads as stopped
    assign running = (st_q == wsc_pkg::WSC_ST_PLAY)
        || (st_q == wsc_pkg::WSC_ST_HOLD);
    assign holding = (st_q == wsc_pkg::WSC_ST_HOLD);
    assign cur_entry = ent_q;

    // memory data registered; word kept while the fifo is full
    logic [GRAN*SW-1:0] gran_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            gv_q <= 1'b0;
            gran_q <= '0;
        end else begin
            gv_q <= push || (gv_q && !fifo_ready);
            if (push) begin
                gran_q <= mem_data;
            end
        end
    end

    wsc_fifo #(.WIDTH(GRAN*SW), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_data(gran_q),
        .in_valid(gv_q),
        .in_ready(fifo_ready),
        .out_data(out_data),
        .out_valid(out_valid),
        .out_ready(out_ready)
    );

    //////////////////////////////////////////////////////////////////////////
    sequence s_trig_while_busy;
        tm == wsc_pkg::WSC_TRIG_TRIG && st_q == wsc_pkg::WSC_ST_PLAY
            && trig_rise && !seg_end;
    endsequence
    a_trig_dropped: assert property (@(posedge clk) disable iff (reset)
        s_trig_while_busy |=> ent_q == $past(ent_q))
        else $error("trigger changed a running play");
    a_reset_idle: assert property (@(posedge clk)
        reset |=> st_q == wsc_pkg::WSC_ST_IDLE && !ev_q)
        else $error("reset did not clear sequencer");
    a_event_held: assert property (@(posedge clk) disable iff (reset)
        ev_q && !ev_use |=> ev_q)
        else $error("stored event lost");
    a_hold_no_push: assert property (@(posedge clk) disable iff (reset)
        st_q == wsc_pkg::WSC_ST_HOLD |-> !mem_req)
        else $error("samples fetched while holding");
    a_cont_start: assert property (@(posedge clk) disable iff (reset)
        st_q == wsc_pkg::WSC_ST_IDLE && run && tm == wsc_pkg::WSC_TRIG_CONT
        |=> st_q == wsc_pkg::WSC_ST_PLAY && ent_q == $past(start_ptr))
        else $error("continuous start missed");
    a_single_hold: assert property (@(posedge clk) disable iff (reset)
        seg_end && !armhold_q && adv == wsc_pkg::WSC_ADV_SINGLE && run
        && !(tm == wsc_pkg::WSC_TRIG_GATE && trig_fall)
        |=> st_q == wsc_pkg::WSC_ST_HOLD)
        else $error("single mode did not hold");
    a_auto_next: assert property (@(posedge clk) disable iff (reset)
        seg_end && !armhold_q && adv == wsc_pkg::WSC_ADV_AUTO && iter_last
        && !loop_end && !last_ent && run
        |=> ent_q == $past(ent_q) + 1'b1)
        else $error("auto mode did not advance");
    a_gate_pause: assert property (@(posedge clk) disable iff (reset)
        tm == wsc_pkg::WSC_TRIG_GATE && trig_fall && run
        && st_q != wsc_pkg::WSC_ST_IDLE
        |=> st_q == wsc_pkg::WSC_ST_PAUSE ##1 !mem_req)
        else $error("gate fall did not pause");
endmodule

/* inc/wsc_defs.svh */
// constants for the waveform sequencer control block
`ifndef WSC_DEFS_SVH
`define WSC_DEFS_SVH
`define WSC_ENTRY_W 8
`define WSC_ADDR_W 24
`define WSC_LEN_W 24
`define WSC_LOOP_W 32
`define WSC_GRAN 8
`define WSC_SAMPLE_W 16
`define WSC_FIFO_DEPTH 16
`define WSC_LAST_F 0
`define WSC_LOOP_END_F 1
`define WSC_ADV_LSB 2
`define WSC_LOOPBACK_LSB 4
`endif

/* inc/wsc_pkg.sv */
// types for the waveform sequencer control block
package wsc_pkg;
    typedef enum logic [1:0] {
        WSC_TRIG_CONT = 2'h0,
        WSC_TRIG_TRIG = 2'h1,
        WSC_TRIG_GATE = 2'h2
    } wsc_trig_t;
    typedef enum logic [1:0] {
        WSC_ADV_AUTO = 2'h0,
        WSC_ADV_COND = 2'h1,
        WSC_ADV_REPEAT = 2'h2,
        WSC_ADV_SINGLE = 2'h3
    } wsc_adv_t;
    typedef enum logic [2:0] {
        WSC_ST_IDLE = 3'h0,
        WSC_ST_PLAY = 3'h1,
        WSC_ST_HOLD = 3'h3,
        WSC_ST_PAUSE = 3'h2
    } wsc_state_t;
endpackage

/* logic/wsc_fifo.sv */
// parameterised sample fifo with valid and ready on both sides
`timescale 1ns/100ps
module wsc_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        in_ready = (cnt_q != (AW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // data read combinationally from memory; read address follows head pointer
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (reset)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule

/* test/wsc_pin_src.sv */
// partner model: trigger, gate, enable and event sources plus sample memory
`timescale 1ns/100ps
`include "wsc_defs.svh"
module wsc_pin_src (
    input wire logic clk,
    input wire logic [`WSC_ADDR_W-1:0] mem_addr,
    input wire logic mem_req,
    output logic [`WSC_GRAN*`WSC_SAMPLE_W-1:0] mem_data,
    output logic trigger_pin,
    output logic event_pin,
    output logic enable_pin
);
    // sample k of a granule is its own address, sample 0 lowest
    function automatic logic [127:0] gran(input logic [23:0] a);
        logic [127:0] r;
        for (int k = 0; k < 8; k++) begin
            r[k*16 +: 16] = a[15:0] + 16'(k);
        end
        return r;
    endfunction
    // no fetch: inverted word, so a read outside a request shows
    always_comb begin
        mem_data = gran(mem_addr);
        if (mem_req !== 1'b1) begin
            mem_data = ~mem_data;
        end
    end
    initial begin
        trigger_pin = 1'b0;
        event_pin = 1'b0;
        enable_pin = 1'b0;
    end
    // pulse wide enough for the two stage synchroniser; 0 trig, 1 event
    task automatic pulse(input int which);
        @(negedge clk);
        if (which == 0) begin
            trigger_pin = 1'b1;
        end else begin
            event_pin = 1'b1;
        end
        repeat (3) @(negedge clk);
        trigger_pin = 1'b0;
        event_pin = 1'b0;
    endtask
    // level on gate (0) or enable (1)
    task automatic level(input int which, input logic v);
        @(negedge clk);
        if (which == 0) begin
            trigger_pin = v;
        end else begin
            enable_pin = v;
        end
    endtask
endmodule

/* test/waveform_sequencer_control_tb.sv */
// self-checking bench for the sequence table walker
`timescale 1ns/100ps
`include "wsc_defs.svh"
module waveform_sequencer_control_tb;
    logic clk, reset, seq_opt, run, armed_mode, infinite_play;
    logic [1:0] trig_mode;
    logic [7:0] start_ptr, tbl_waddr, cur_entry;
    logic trigger_pin, event_pin, enable_pin, tbl_we;
    logic [23:0] tbl_base, tbl_len, mem_addr;
    logic [31:0] tbl_loops;
    logic [11:0] tbl_ctrl;
    logic mem_req, out_valid, out_ready, running, holding;
    logic [127:0] mem_data, out_data;
    logic [127:0] q[$];
    int errors = 0;
    int num_checks = 0;
    wsc_sequencer dut (
        .clk(clk), .reset(reset), .sequencing_option(seq_opt),
        .run(run), .trig_mode(trig_mode), .armed_mode(armed_mode),
        .infinite_play(infinite_play), .start_ptr(start_ptr),
        .trigger_pin(trigger_pin), .event_pin(event_pin),
        .enable_pin(enable_pin), .tbl_we(tbl_we), .tbl_waddr(tbl_waddr),
        .tbl_base(tbl_base), .tbl_len(tbl_len), .tbl_loops(tbl_loops),
        .tbl_ctrl(tbl_ctrl), .mem_addr(mem_addr), .mem_req(mem_req),
        .mem_data(mem_data), .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready), .running(running), .holding(holding),
        .cur_entry(cur_entry)
    );
    wsc_pin_src src (
        .clk(clk), .mem_addr(mem_addr), .mem_req(mem_req),
        .mem_data(mem_data), .trigger_pin(trigger_pin),
        .event_pin(event_pin), .enable_pin(enable_pin)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // collect every granule accepted at the fifo output
    always @(posedge clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            q.push_back(out_data);
        end
    end
    //////////////////////////////////////////////////////////////////////
    function automatic logic [127:0] gran(input logic [23:0] a);
        logic [127:0] r;
        for (int k = 0; k < 8; k++) begin
            r[k*16 +: 16] = a[15:0] + 16'(k);
        end
        return r;
    endfunction
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait for the running flag to reach a level
    task automatic wait_run(input logic v, input int bound);
        int i;
        for (i = 0; i < bound && running !== v; i++) begin
            @(negedge clk);
        end
        if (running !== v) begin
            errors++;
            $display("[ERR] t=%0t wait for running=%h ran out", $time, v);
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] b,
                      input logic [31:0] n, input logic [11:0] c);
        @(negedge clk);
        tbl_we = 1'b1;
        tbl_waddr = a;
        tbl_base = b;
        // lengths kept at whole granules
        tbl_len = 24'h00_0010 >> c[8];
        tbl_loops = n;
        tbl_ctrl = {4'h0, c[7:0]};
        @(negedge clk);
        tbl_we = 1'b0;
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {seq_opt, run, armed_mode, infinite_play, tbl_we} = 5'h10;
        seq_opt = 1'b1;
        trig_mode = 2'h1;
        {start_ptr, tbl_waddr, tbl_ctrl} = 28'h000_0000;
        {tbl_base, tbl_len, tbl_loops} = 80'h0;
        out_ready = 1'b0;
        settle(4);
        reset = 1'b0;
        // idle with no output after reset
        chk(running, 1'b0);
        chk(out_valid, 1'b0);
        // entry 0: two granules, twelve loops, last entry, auto
        wr(8'h00, 24'h00_0100, 32'h0000_000C, 12'h001);
        run = 1'b1;
        src.pulse(0);
        settle(40);
        // fifo full: play stalls but stays alive
        chk(running, 1'b1);
        chk(out_valid, 1'b1);
        src.pulse(0);
        out_ready = 1'b1;
        wait_run(1'b0, 200);
        settle(20);
        chk(running, 1'b0);
        chk(128'(q.size()), 128'h18);
        for (int i = 0; i < 24; i++) begin
            chk(q[i], gran(24'h00_0100 + 24'((i % 2) * 8)));
        end
        $display("test fill_drain done");
        // two entries share one memory block, start pointer at 1
        q.delete();
        wr(8'h01, 24'h00_0200, 32'h0000_0001, 12'h100);
        wr(8'h02, 24'h00_0200, 32'h0000_0001, 12'h101);
        start_ptr = 8'h01;
        src.pulse(0);
        settle(30);
        chk(128'(q.size()), 128'h2);
        chk(q[0], gran(24'h00_0200));
        chk(q[1], gran(24'h00_0200));
        $display("test shared_block done");
        // repeated advance holds until an event, then moves on
        q.delete();
        wr(8'h04, 24'h00_0300, 32'h0000_0002, 12'h108);
        wr(8'h05, 24'h00_0400, 32'h0000_0001, 12'h101);
        start_ptr = 8'h04;
        src.pulse(0);
        settle(30);
        chk(holding, 1'b1);
        chk(q[0], gran(24'h00_0300));
        chk(q[1], gran(24'h00_0300));
        src.pulse(1);
        wait_run(1'b0, 60);
        settle(5);
        chk(q[q.size()-1], gran(24'h00_0400));
        $display("test repeat_advance done");
        // continuous: starts with no trigger and never ends
        start_ptr = 8'h00;
        trig_mode = 2'h0;
        wait_run(1'b1, 10);
        settle(100);
        chk(running, 1'b1);
        run = 1'b0;
        wait_run(1'b0, 10);
        $display("test continuous done");
        // gated: top level left on auto, the continuous case
        trig_mode = 2'h2;
        run = 1'b1;
        src.level(0, 1'b1);
        wait_run(1'b1, 10);
        src.level(0, 1'b0);
        wait_run(1'b0, 10);
        src.level(0, 1'b1);
        wait_run(1'b1, 10);
        src.level(0, 1'b0);
        wait_run(1'b0, 10);
        $display("test gated done");
        // armed triggered needs the enable flag first
        run = 1'b0;
        settle(3);
        trig_mode = 2'h1;
        armed_mode = 1'b1;
        run = 1'b1;
        src.pulse(0);
        settle(20);
        chk(running, 1'b0);
        src.level(1, 1'b1);
        src.pulse(0);
        wait_run(1'b1, 10);
        src.level(1, 1'b0);
        // reset in mid play; also drops the stored enable flag
        reset = 1'b1;
        settle(2);
        reset = 1'b0;
        chk(running, 1'b0);
        chk(out_valid, 1'b0);
        // without the option, armed is ignored: self armed
        seq_opt = 1'b0;
        src.pulse(0);
        wait_run(1'b1, 10);
        wait_run(1'b0, 200);
        $display("test arm_modes done");
        // entries 8 and 9 form a loop passed twice; entry 8 plays twice per pass
        settle(5);
        q.delete();
        seq_opt = 1'b1;
        armed_mode = 1'b0;
        wr(8'h08, 24'h00_0500, 32'h0000_0002, 12'h100);
        wr(8'h09, 24'h00_0600, 32'h0000_0001, 12'h183);
        start_ptr = 8'h08;
        src.pulse(0);
        wait_run(1'b0, 60);
        settle(5);
        chk(128'(q.size()), 128'h6);
        for (int i = 0; i < 6; i++) begin
            chk(q[i], gran((i % 3 == 2) ? 24'h00_0600 : 24'h00_0500));
        end
        $display("test loop done");
        // single then conditional advance, each released by events
        q.delete();
        wr(8'h0A, 24'h00_0700, 32'h0000_0002, 12'h10C);
        wr(8'h0B, 24'h00_0800, 32'h0000_0001, 12'h105);
        start_ptr = 8'h0A;
        src.pulse(0);
        settle(10);
        chk(holding, 1'b1);
        chk(128'(q.size()), 128'h1);
        src.pulse(1);
        settle(10);
        chk(holding, 1'b1);
        chk(128'(q.size()), 128'h2);
        src.pulse(1);
        settle(10);
        chk(holding, 1'b0);
        chk(running, 1'b1);
        src.pulse(1);
        wait_run(1'b0, 30);
        settle(5);
        chk(q[1], gran(24'h00_0700));
        chk(q[q.size()-1], gran(24'h00_0800));
        $display("test single_cond done");
        // infinite play keeps a triggered run going past its count
        infinite_play = 1'b1;
        start_ptr = 8'h01;
        src.pulse(0);
        settle(30);
        chk(running, 1'b1);
        run = 1'b0;
        wait_run(1'b0, 10);
        infinite_play = 1'b0;
        $display("test infinite done");
        tally_and_finish();
    end
endmodule
